// ### rtl/pcr_map.vh
// register indexes, field positions, reset values and codes of the port crossbar
`ifndef PCR_MAP_VH
`define PCR_MAP_VH

// ----------------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PCR_IDX_ROUTE0      10'h0e1
`define PCR_IDX_ROUTE1      10'h0e2
`define PCR_IDX_PORT0       10'h080
`define PCR_IDX_PORT1       10'h090
`define PCR_IDX_PORT2       10'h0a0
`define PCR_IDX_MODE0       10'h0a4
`define PCR_IDX_MODE1       10'h0a5
`define PCR_IDX_SKIP0       10'h0d4
`define PCR_IDX_SKIP1       10'h0d5
`define PCR_ADDR_W          12
`define PCR_IDX_HI          11
`define PCR_IDX_LO          2

// ----------------------------------------------------------------------------
// fields of route register 0 and 1, and the port 2 write mask
// ----------------------------------------------------------------------------
`define PCR_R0_UART         0
`define PCR_R0_SPI          1
`define PCR_R0_TWI          2
`define PCR_R0_SYSCK        3
`define PCR_R0_CMPS         4
`define PCR_R0_CMPA         5
`define PCR_R0_WMASK        8'h3f
`define PCR_R1_XBAR_EN      6
`define PCR_R1_WMASK        8'h40
`define PCR_P2_WMASK        8'h01

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PCR_RST_ROUTE       8'h00
`define PCR_RST_LATCH       8'hff
`define PCR_RST_MODE        8'h00
`define PCR_RST_SKIP        8'h00
`define PCR_RST_WORD        32'h0000_0000

// ----------------------------------------------------------------------------
// routed function slots in priority order, and pin function codes
// ----------------------------------------------------------------------------
`define PCR_FN_SCK          4'h0
`define PCR_FN_MISO         4'h1
`define PCR_FN_MOSI         4'h2
`define PCR_FN_NSS          4'h3
`define PCR_FN_SDA          4'h4
`define PCR_FN_SCL          4'h5
`define PCR_FN_CMPS         4'h6
`define PCR_FN_CMPA         4'h7
`define PCR_FN_SYSCK        4'h8
`define PCR_FN_NUM          9
`define PCR_FN_NONE         4'h9
`define PCR_FN_UTX          4'hd
`define PCR_FN_URX          4'he
`define PCR_FN_GPIO         4'hf
`define PCR_PIN_UTX         4
`define PCR_PIN_URX         5
`define PCR_XPINS           16
`define PCR_PINS            17
`define PCR_DBG_PIN         16

`endif

// ### rtl/pcr_decoder.v
// priority decoder: assigns enabled peripheral functions to crossbar pins
`include "pcr_map.vh"
`default_nettype none

module pcr_decoder (
  input  wire [`PCR_FN_NUM-1:0]   fn_en,
  input  wire [`PCR_XPINS-1:0]    skip,
  input  wire                     uart_en,
  output reg  [4*`PCR_XPINS-1:0]  pin_fn
);

  // ----------------------------------------------------------------------------
  // next enabled slot at or after a start slot, none when exhausted
  // ----------------------------------------------------------------------------
  function [3:0] next_fn;
    input [`PCR_FN_NUM-1:0] en;
    input [3:0]             start;
    integer                 i;
    begin
      next_fn = `PCR_FN_NONE;
      for (i = `PCR_FN_NUM - 1; i >= 0; i = i - 1) begin
        if (en[i] && (i >= start)) begin
          next_fn = i[3:0];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // walk pins from lowest up; uart pins are fixed and never taken by others
  // ----------------------------------------------------------------------------
  reg     [3:0] k;
  reg     [3:0] f;
  integer       p;
  always @* begin
    k      = 4'h0;
    f      = `PCR_FN_NONE;
    pin_fn = {4*`PCR_XPINS{1'b1}};
    for (p = 0; p < `PCR_XPINS; p = p + 1) begin
      if (uart_en && (p == `PCR_PIN_UTX)) begin
        pin_fn[4*p +: 4] = `PCR_FN_UTX;
      end else if (uart_en && (p == `PCR_PIN_URX)) begin
        pin_fn[4*p +: 4] = `PCR_FN_URX;
      end else if (!skip[p]) begin
        f = next_fn(fn_en, k);
        if (f != `PCR_FN_NONE) begin
          pin_fn[4*p +: 4] = f;
          k                = f + 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/pcr_crossbar.v
// port crossbar top: apb registers, pin synchronisers, routing and pin drivers
//
// Contract
// - port 0 and port 1 pins act as gpio or carry a routed peripheral signal
// - port 2 bit 0 is gpio shared with the debug data line
// - reading a port latch returns present pin levels regardless of routing
// - only selected functions are placed, pins allocated in fixed priority order
// - each port 0/1 pin drives push-pull or open-drain per its mode bit
// - route register 0 bits 7:6 read zero and ignore writes
// - bit 5 routes the unsynchronised comparator output, else it stays off
// - bit 4 routes the synchronised comparator output, else it stays off
// - bit 3 routes the system clock out, else it is not output
// - bit 2 routes two-wire data and clock lines, else unavailable
// - bit 1 routes spi on three or four pins per spi configuration
// - bit 0 puts uart transmit on p0.4 and receive on p0.5
`include "pcr_map.vh"
`default_nettype none

module pcr_crossbar (
  input  wire                     mclk,
  input  wire                     reset_n,
  // apb slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`PCR_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  // package pins: p0 in bits 7:0, p1 in bits 15:8, p2.0 in bit 16
  input  wire [`PCR_PINS-1:0]     pin_in,
  output reg  [`PCR_PINS-1:0]     pin_out,
  output reg  [`PCR_PINS-1:0]     pin_oe,
  // routed peripheral slots, indexed by function slot
  input  wire [`PCR_FN_NUM-1:0]   periph_out,
  input  wire [`PCR_FN_NUM-1:0]   periph_drive,
  output reg  [`PCR_FN_NUM-1:0]   periph_in,
  input  wire                     spi_nss_en,
  input  wire                     uart_transmit_line,
  output reg                      uart_receive_line,
  // debug data line sharing p2.0
  input  wire                     debug_data_drive,
  input  wire                     debug_data_out,
  output reg                      debug_data_line
);

  // ----------------------------------------------------------------------------
  // register index decode, shared by read and write paths
  // ----------------------------------------------------------------------------
  function is_reg;
    input [`PCR_ADDR_W-1:0] a;
    input [9:0]             idx;
    begin
      is_reg = (a[`PCR_IDX_HI:`PCR_IDX_LO] == idx);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg  [7:0]               route0_q;
  reg  [7:0]               route1_q;
  reg  [7:0]               latch0_q;
  reg  [7:0]               latch1_q;
  reg  [7:0]               latch2_q;
  reg  [7:0]               mode0_q;
  reg  [7:0]               mode1_q;
  reg  [7:0]               skip0_q;
  reg  [7:0]               skip1_q;
  reg  [`PCR_PINS-1:0]     pin_s1_q;
  reg  [`PCR_PINS-1:0]     pin_s2_q;
  reg  [31:0]              rdata_d;
  reg                      mapped_d;
  reg  [`PCR_PINS-1:0]     pin_out_d;
  reg  [`PCR_PINS-1:0]     pin_oe_d;
  reg  [`PCR_FN_NUM-1:0]   periph_in_d;
  reg  [`PCR_FN_NUM-1:0]   fn_en;
  wire [4*`PCR_XPINS-1:0]  pin_fn;
  wire                     xbar_en;
  wire                     wr_take;
  wire                     acc_first;
  wire [`PCR_XPINS-1:0]    xlatch;
  wire [`PCR_XPINS-1:0]    xmode;

  assign xbar_en   = route1_q[`PCR_R1_XBAR_EN];
  assign xlatch    = {latch1_q, latch0_q};
  assign xmode     = {mode1_q, mode0_q};
  // one wait state: data is prepared in the first access cycle
  assign acc_first = psel & penable & ~pready;
  assign wr_take   = psel & penable & pready & pwrite & ~pslverr;

  // ----------------------------------------------------------------------------
  // pin synchronisers: only the second stage is read anywhere
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      pin_s1_q <= {`PCR_PINS{1'b1}};
      pin_s2_q <= {`PCR_PINS{1'b1}};
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------------------
  // read mux; port registers return pin levels, not the written latch
  // ----------------------------------------------------------------------------
  always @* begin
    rdata_d  = `PCR_RST_WORD;
    mapped_d = 1'b1;
    if (is_reg(paddr, `PCR_IDX_ROUTE0)) begin
      rdata_d[7:0] = route0_q & `PCR_R0_WMASK;
    end else if (is_reg(paddr, `PCR_IDX_ROUTE1)) begin
      rdata_d[7:0] = route1_q;
    end else if (is_reg(paddr, `PCR_IDX_PORT0)) begin
      rdata_d[7:0] = pin_s2_q[7:0];
    end else if (is_reg(paddr, `PCR_IDX_PORT1)) begin
      rdata_d[7:0] = pin_s2_q[15:8];
    end else if (is_reg(paddr, `PCR_IDX_PORT2)) begin
      rdata_d[0] = pin_s2_q[`PCR_DBG_PIN];
    end else if (is_reg(paddr, `PCR_IDX_MODE0)) begin
      rdata_d[7:0] = mode0_q;
    end else if (is_reg(paddr, `PCR_IDX_MODE1)) begin
      rdata_d[7:0] = mode1_q;
    end else if (is_reg(paddr, `PCR_IDX_SKIP0)) begin
      rdata_d[7:0] = skip0_q;
    end else if (is_reg(paddr, `PCR_IDX_SKIP1)) begin
      rdata_d[7:0] = skip1_q;
    end else begin
      mapped_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // apb handshake: pready high in the second access cycle, unmapped gets pslverr
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PCR_RST_WORD;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped_d;
      if (acc_first && !pwrite) begin
        prdata <= rdata_d;
      end else if (!acc_first) begin
        prdata <= `PCR_RST_WORD;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // register writes, taken only at the edge that completes the transfer
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      route0_q <= `PCR_RST_ROUTE;
      route1_q <= `PCR_RST_ROUTE;
      latch0_q <= `PCR_RST_LATCH;
      latch1_q <= `PCR_RST_LATCH;
      latch2_q <= `PCR_RST_LATCH & `PCR_P2_WMASK;
      mode0_q  <= `PCR_RST_MODE;
      mode1_q  <= `PCR_RST_MODE;
      skip0_q  <= `PCR_RST_SKIP;
      skip1_q  <= `PCR_RST_SKIP;
    end else if (wr_take) begin
      if (is_reg(paddr, `PCR_IDX_ROUTE0)) begin
        route0_q <= pwdata[7:0] & `PCR_R0_WMASK;
      end
      if (is_reg(paddr, `PCR_IDX_ROUTE1)) begin
        route1_q <= pwdata[7:0] & `PCR_R1_WMASK;
      end
      if (is_reg(paddr, `PCR_IDX_PORT0)) begin
        latch0_q <= pwdata[7:0];
      end
      if (is_reg(paddr, `PCR_IDX_PORT1)) begin
        latch1_q <= pwdata[7:0];
      end
      if (is_reg(paddr, `PCR_IDX_PORT2)) begin
        latch2_q <= pwdata[7:0] & `PCR_P2_WMASK;
      end
      if (is_reg(paddr, `PCR_IDX_MODE0)) begin
        mode0_q <= pwdata[7:0];
      end
      if (is_reg(paddr, `PCR_IDX_MODE1)) begin
        mode1_q <= pwdata[7:0];
      end
      if (is_reg(paddr, `PCR_IDX_SKIP0)) begin
        skip0_q <= pwdata[7:0];
      end
      if (is_reg(paddr, `PCR_IDX_SKIP1)) begin
        skip1_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // function slots requested by the route register, in priority order
  // ----------------------------------------------------------------------------
  always @* begin
    fn_en                = {`PCR_FN_NUM{1'b0}};
    fn_en[`PCR_FN_SCK]   = route0_q[`PCR_R0_SPI];
    fn_en[`PCR_FN_MISO]  = route0_q[`PCR_R0_SPI];
    fn_en[`PCR_FN_MOSI]  = route0_q[`PCR_R0_SPI];
    fn_en[`PCR_FN_NSS]   = route0_q[`PCR_R0_SPI] & spi_nss_en;
    fn_en[`PCR_FN_SDA]   = route0_q[`PCR_R0_TWI];
    fn_en[`PCR_FN_SCL]   = route0_q[`PCR_R0_TWI];
    fn_en[`PCR_FN_CMPS]  = route0_q[`PCR_R0_CMPS];
    fn_en[`PCR_FN_CMPA]  = route0_q[`PCR_R0_CMPA];
    fn_en[`PCR_FN_SYSCK] = route0_q[`PCR_R0_SYSCK];
  end

  pcr_decoder u_decoder (
    .fn_en   (fn_en),
    .skip    ({skip1_q, skip0_q}),
    .uart_en (route0_q[`PCR_R0_UART]),
    .pin_fn  (pin_fn)
  );

  // ----------------------------------------------------------------------------
  // pin drivers: open-drain drives only a low, push-pull drives both levels
  // ----------------------------------------------------------------------------
  reg     [3:0] code;
  reg           val;
  reg           drv;
  integer       p;
  always @* begin
    code        = `PCR_FN_GPIO;
    val         = 1'b1;
    drv         = 1'b0;
    pin_out_d   = {`PCR_PINS{1'b0}};
    pin_oe_d    = {`PCR_PINS{1'b0}};
    periph_in_d = {`PCR_FN_NUM{1'b1}};
    for (p = 0; p < `PCR_XPINS; p = p + 1) begin
      code = pin_fn[4*p +: 4];
      case (code)
        `PCR_FN_GPIO: begin
          val = xlatch[p];
          drv = 1'b1;
        end
        `PCR_FN_UTX: begin
          val = uart_transmit_line;
          drv = 1'b1;
        end
        `PCR_FN_URX: begin
          val = 1'b1;
          drv = 1'b0;
        end
        default: begin
          val = periph_out[code];
          drv = periph_drive[code];
          periph_in_d[code] = pin_s2_q[p];
        end
      endcase
      pin_out_d[p] = xmode[p] & val;
      pin_oe_d[p]  = xbar_en & drv & (xmode[p] | ~val);
    end
    // p2.0 has no mode setting: open-drain gpio unless debug owns it
    if (debug_data_drive) begin
      pin_out_d[`PCR_DBG_PIN] = debug_data_out;
      pin_oe_d[`PCR_DBG_PIN]  = 1'b1;
    end else begin
      pin_out_d[`PCR_DBG_PIN] = 1'b0;
      pin_oe_d[`PCR_DBG_PIN]  = xbar_en & ~latch2_q[0];
    end
  end

  // ----------------------------------------------------------------------------
  // registered outputs; costs one cycle of latency on every routed signal
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      pin_out           <= {`PCR_PINS{1'b0}};
      pin_oe            <= {`PCR_PINS{1'b0}};
      periph_in         <= {`PCR_FN_NUM{1'b1}};
      uart_receive_line <= 1'b1;
      debug_data_line   <= 1'b1;
    end else begin
      pin_out           <= pin_out_d;
      pin_oe            <= pin_oe_d;
      periph_in         <= periph_in_d;
      uart_receive_line <= route0_q[`PCR_R0_UART] ?
                           pin_s2_q[`PCR_PIN_URX] : 1'b1;
      debug_data_line   <= pin_s2_q[`PCR_DBG_PIN];
    end
  end

endmodule

`default_nettype wire

// ### tb/pcr_pin_model.sv
// package-pin model for the port crossbar: pull-ups and outside pull-downs
`default_nettype none
module pcr_pin_model (
  input  wire logic [16:0] pin_out,
  input  wire logic [16:0] pin_oe,
  input  wire logic [16:0] ext_low,
  output wire logic [16:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin rises to its pull-up; outside parts can only pull low, so
  // a driven high against an outside low reads low like a real wired pin
  assign pin_in = ((pin_out & pin_oe) | ~pin_oe) & ~ext_low;
endmodule
`default_nettype wire

// ### tb/pcr_crossbar_checker.sv
// assertions on the register-bus and debug-pin ports of the port crossbar
`include "pcr_map.vh"
`default_nettype none
module pcr_crossbar_checker (
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`PCR_ADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [`PCR_PINS-1:0]   pin_in,
  input wire logic [`PCR_PINS-1:0]   pin_out,
  input wire logic [`PCR_PINS-1:0]   pin_oe,
  input wire logic                   debug_data_drive,
  input wire logic                   debug_data_out,
  input wire logic                   debug_data_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ------
  // helpers
  // ------
  // cycles since reset: the synchroniser history is only valid after three
  always_ff @(posedge mclk) begin
    if (!reset_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_ready_one_wait: assert property (s_setup |=> s_answer)
    else $error("pready not on second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access cycle");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_route_reserved: assert property (pready && !pwrite &&
    paddr[11:2] == `PCR_IDX_ROUTE0 |-> prdata[7:6] == 2'h0 && !pslverr)
    else $error("route0 reserved bits not zero");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  a_debug_drive: assert property (debug_data_drive |=> pin_oe[16] &&
    pin_out[16] == $past(debug_data_out))
    else $error("debug logic does not own shared pin");
  a_debug_sync: assert property (up_q == 2'h3 |->
    debug_data_line == $past(pin_in[16], 3))
    else $error("debug data line not pin level");
endmodule
bind pcr_crossbar pcr_crossbar_checker u_chk (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .debug_data_drive(debug_data_drive),
  .debug_data_out(debug_data_out), .debug_data_line(debug_data_line)
);
`default_nettype wire

// ### tb/tb_top.sv
// bench for the port crossbar: register access and pin routing checks
`include "pcr_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset_n, psel, penable, pwrite, err, pready, pslverr;
  logic        spi_nss_en, utx, urx, dbg_drv, dbg_out, dbg_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [16:0] pin_in, pin_out, pin_oe, ext_low;
  logic [8:0]  periph_out, periph_drive, periph_in;
  int          n_errors = 0;
  int          checked = 0;
  // per routing bit: p0 drive, and {rx, periph_in} with one routed pin low
  // routed output pins read back their own level, so driven lows show in periph_in
  logic [7:0]  exp_o [6] = '{8'h30, 8'h05, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [9:0]  exp_i [6] = '{10'h1ff, 10'h3f4, 10'h3cf, 10'h2ff, 10'h3bf, 10'h37f};
  localparam logic [11:0] A_R0 = {`PCR_IDX_ROUTE0, 2'h0};
  localparam logic [11:0] A_R1 = {`PCR_IDX_ROUTE1, 2'h0};
  localparam logic [11:0] A_P0 = {`PCR_IDX_PORT0, 2'h0};
  localparam logic [11:0] A_P1 = {`PCR_IDX_PORT1, 2'h0};
  localparam logic [11:0] A_P2 = {`PCR_IDX_PORT2, 2'h0};
  localparam logic [11:0] A_M0 = {`PCR_IDX_MODE0, 2'h0};
  localparam logic [11:0] A_M1 = {`PCR_IDX_MODE1, 2'h0};
  localparam logic [11:0] A_S0 = {`PCR_IDX_SKIP0, 2'h0};

  pcr_crossbar DUT (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_drive(periph_drive), .periph_in(periph_in), .spi_nss_en(spi_nss_en),
    .uart_transmit_line(utx), .uart_receive_line(urx), .debug_data_drive(dbg_drv),
    .debug_data_out(dbg_out), .debug_data_line(dbg_line)
  );
  pcr_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low),
    .pin_in(pin_in));

  // ------
  // tasks
  // ------
  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // pready is judged at the rising edge; that same edge takes the read data
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t no bus answer", $time);
      close_out();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // pins follow in one cycle, pin levels come back through the synchroniser
  task automatic settle();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ------
  // main sequence
  // ------
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ext_low = 17'h0;
    periph_out = 9'h155;
    periph_drive = 9'h1ff;
    {spi_nss_en, utx, dbg_out, dbg_drv} = 4'he;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(A_R0, 32'h0);
    wr(A_R0, 32'hff);
    rdc(A_R0, 32'h3f);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    rdc(A_P0, 32'hff);
    $display("test registers done");
    // crossbar on with nothing routed: every port 0/1 pin is push-pull gpio
    wr(A_R0, 32'h0);
    wr(A_R1, 32'h40);
    wr(A_M0, 32'hff);
    wr(A_M1, 32'hff);
    wr(A_P0, 32'h0);
    wr(A_P1, 32'h0);
    settle();
    chk(32'({pin_oe[15:0], pin_out[15:0]}), 32'hffff_0000);
    rdc(A_P1, 32'h0);
    $display("test gpio done");
    for (int b = 0; b < 6; b++) begin
      wr(A_R0, 32'h1 << b);
      ext_low <= (b == 0) ? 17'h20 : 17'h1;
      settle();
      chk(32'(pin_out[7:0]), 32'(exp_o[b]));
      chk(32'({urx, periph_in}), 32'(exp_i[b]));
      chk(32'(pin_oe[5]), 32'(b != 0));
      @(posedge mclk);
      ext_low <= 17'h0;
    end
    $display("test single routes done");
    wr(A_R0, 32'h3f);
    settle();
    chk(32'({pin_out[10:6], pin_out[4:0]}), 32'h2b5);
    rdc(A_P0, 32'h75);
    // skipping p0.0 moves nss past the uart pins to p0.6, every other non-uart slot one pin up, and leaves p0.0 to its latch
    wr(A_S0, 32'h1);
    rdc(A_S0, 32'h1);
    settle();
    chk(32'({pin_out[11:6], pin_out[3:0]}), 32'h2aa);
    wr(A_S0, 32'h0);
    $display("test priority done");
    // three-wire spi leaves p0.3 to its latch; then the same pins open-drain
    spi_nss_en <= 1'b0;
    wr(A_P0, 32'h8);
    wr(A_R0, 32'h3);
    settle();
    chk(32'(pin_out[4:0]), 32'h1d);
    wr(A_M0, 32'h0);
    settle();
    chk(32'({pin_oe[4:0], pin_out[4:0]}), 32'h40);
    $display("test drive modes done");
    @(posedge mclk);
    dbg_out <= 1'b0;
    dbg_drv <= 1'b1;
    settle();
    chk(32'({pin_oe[16], pin_out[16], dbg_line}), 32'h4);
    rdc(A_P2, 32'h0);
    dbg_drv <= 1'b0;
    settle();
    chk(32'(dbg_line), 32'h1);
    $display("test debug pin done");
    close_out();
  end
endmodule
`default_nettype wire
